/* inc/settings_store_consts.svh */
`ifndef SETTINGS_STORE_CONSTS_SVH
`define SETTINGS_STORE_CONSTS_SVH
// Notes on behaviour
// - active settings live in volatile ram
// - power-up copies factory area into active, reboot copies startup area
// - load-custom copies custom area into active
// - save-custom copies active into custom area
// - uart restore loads factory area into active
// - three restore commands, one per interface
// - save copies whole active area to startup
// - deferred settings apply only after startup save; boot copies also load them here
// - custom line: header, command, apostrophes, terminator
// - custom line persists, redefines factory defaults
// - redefined defaults need reboot then uart restore, or reboot alone in fast boot
// - reboot command resets the engine
// - output-line command sends stored custom line
// - no stored custom line, send nothing
// - fast boot ignores startup area, uses defaults
// - fast-boot command: query, Q0 disable, Q1 enable
// - query answers disabled or enabled text plus cr
// - fast boot leaves boot time unchanged
// - ready for commands within boot time
// - packet framing esc/cr or stx/etx

// framing and command characters
`define CH_ESC 8'h1b
`define CH_CR 8'h0d
`define CH_STX 8'h02
`define CH_ETX 8'h03
`define CH_APOS 8'h27
`define CH_LBR 8'h5b
`define CH_Q 8'h51
`define CH_ONE 8'h31

// two-character command codes
`define TOK_RESTORE_UART 16'h5532
`define TOK_RESTORE_HID 16'h5355
`define TOK_SAVE_STARTUP 16'h5a32
`define TOK_REBOOT 16'h5256
`define TOK_FB_OFF 16'h5130
`define TOK_FB_ON 16'h5131

// four-character command codes
`define TOK_RESTORE_COM 32'h5b433031
`define TOK_LOAD_CUSTOM 32'h5b424150
`define TOK_SAVE_CUSTOM 32'h5b424151
`define TOK_SET_LINE 32'h5b454659
`define TOK_OUT_LINE 32'h5b45465a
`define TOK_FAST_BOOT 32'h5b454658

// answer lengths, carriage return included
`define MSG_DIS_LEN 23
`define MSG_EN_LEN 22

// timing
`define CLK_KHZ 25000
`define BOOT_TYP_MS 360
`define BOOT_MAX_MS 1000
`define BOOT_TYP_CYC (`BOOT_TYP_MS * `CLK_KHZ)
`endif

/* inc/settings_store_pkg.sv */
`default_nettype none
package settings_store_pkg;
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_IDLE = 3'h1,
    ST_BODY = 3'h3,
    ST_COPY = 3'h2,
    ST_TX = 3'h6,
    ST_FWD = 3'h7,
    ST_REPLAY = 3'h5,
    ST_CLCAP = 3'h4
  } state_t;
  typedef enum logic [1:0] {
    AREA_ACTIVE = 2'h0,
    AREA_STARTUP = 2'h1,
    AREA_CUSTOM = 2'h2,
    AREA_FACTORY = 2'h3
  } area_t;
  typedef enum logic [1:0] {
    IF_UART = 2'h0,
    IF_USBCOM = 2'h1,
    IF_USBHID = 2'h2
  } iface_t;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } fwd_beat_t;
endpackage
`default_nettype wire

/* rtl/settings_store_command_unit.sv */
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "settings_store_consts.svh"
module settings_store_command_unit
  import settings_store_pkg::*;
#(
  parameter int NW = 16,
  parameter int WW = 16,
  parameter int AW = $clog2(NW),
  parameter int CL_DEPTH = 64,
  parameter int BOOT_CYCLES = `BOOT_TYP_CYC,
  parameter int DEFER_IDX = 0,
  // arbitrary pattern standing in for the shipped defaults
  parameter logic [15:0] FACTORY_SEED = 16'h5a00
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // command bytes from the uart receiver
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  // answer bytes to the uart transmitter
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  // commands for other handlers
  output logic fwdValid,
  output fwd_beat_t fwdBeat,
  input wire logic fwdReady,
  // active settings port
  input wire logic setWrEn,
  input wire logic [AW-1:0] setAddr,
  input wire logic [WW-1:0] setWrData,
  output logic [WW-1:0] setRdData,
  output logic setBusy,
  // status
  output logic cmdReady,
  output logic engineReboot,
  output logic fastBootOn,
  output logic [WW-1:0] deferredCfg
);
  localparam int EW = $clog2(CL_DEPTH + 1);
  localparam int CW = $clog2(CL_DEPTH);
  localparam logic [8*`MSG_DIS_LEN-1:0] MSG_DIS =
    {"Disable Fast Boot Mode", `CH_CR};
  localparam logic [8*`MSG_EN_LEN-1:0] MSG_EN =
    {"Enable Fast Boot Mode", `CH_CR};

  // ---------------------------------------------------------------
  // storage areas
  // ---------------------------------------------------------------
  logic [WW-1:0] actMem [NW];
  logic [WW-1:0] stMem [NW];
  logic [WW-1:0] cuMem [NW];
  logic [7:0] clMem [CL_DEPTH];

  state_t state_r, retState_r;
  logic [31:0] tokVal_r, nTok;
  logic [2:0] tokCnt_r, nCnt;
  logic tokLong_r, hdrStx_r, pendFb_r, replayPend_r, txLine_r;
  logic [EW-1:0] emIdx_r, emLen_r;
  logic emLast_r;
  logic [31:0] fwdBuf_r;
  logic cpAct_r, stValid_r, cuValid_r;
  logic [AW-1:0] cpIdx_r;
  area_t cpSrc_r, cpDst_r, cpSrcN, cpDstN;
  iface_t cpIf_r, cpIfN;
  logic cpStart;
  logic [WW-1:0] cpWord, deferred_r, setRdData_r;
  logic [31:0] bootCnt_r;
  logic cmdReady_r, rebootPulse_r, armed_r;
  logic [EW-1:0] clCnt_r, clLen_r;
  logic clValid_r, capOpen_r, fbMode_r;
  logic txValid_r, fwdValid_r;
  logic [7:0] txData_r, emByte;
  fwd_beat_t fwdBeat_r;
  logic take, inBody, isTerm, isLong, tokDone, holdFb, holdFbGo;
  logic hitFbSet, hitFbQuery, hitFbCmd, hitRestU, hitRestC, hitRestH;
  logic hitSaveSt, hitReboot, hitLoadCu, hitSaveCu, hitSetLine;
  logic hitOutLine, hitUnknown, bootDone, emLoad, emIsLast;
  logic txFree, fwdFree;

  function automatic logic [WW-1:0] factoryWord(input iface_t ifc,
                                                input logic [AW-1:0] idx);
    factoryWord = WW'(FACTORY_SEED) ^ WW'({logic'(1'b0), ifc, idx});
  endfunction

  // ---------------------------------------------------------------
  // byte classification and command decode
  // ---------------------------------------------------------------
  always_comb begin
    inBody = (state_r == ST_BODY);
    // a pending fast-boot command peeks at the next byte before taking it
    holdFb = pendFb_r && (tokCnt_r == 3'h0) && (rxData != `CH_Q);
    holdFbGo = inBody && rxValid && holdFb;
    rxReady = (state_r == ST_IDLE) || (state_r == ST_CLCAP) ||
              (inBody && !holdFb);
    take = rxValid && rxReady;
    isTerm = hdrStx_r ? (rxData == `CH_ETX) : (rxData == `CH_CR);
    nTok = {tokVal_r[23:0], rxData};
    nCnt = 3'(tokCnt_r + 3'h1);
    isLong = tokLong_r || ((tokCnt_r == 3'h0) && (rxData == `CH_LBR));
    tokDone = inBody && take && !isTerm &&
              (isLong ? (nCnt == 3'h4) : (nCnt == 3'h2));
    hitFbSet = tokDone && pendFb_r && !isLong &&
               (nTok[15:0] == `TOK_FB_OFF || nTok[15:0] == `TOK_FB_ON);
    hitFbQuery = holdFbGo || (tokDone && pendFb_r && !hitFbSet);
    hitRestU = tokDone && !pendFb_r && !isLong &&
               nTok[15:0] == `TOK_RESTORE_UART;
    hitRestH = tokDone && !pendFb_r && !isLong &&
               nTok[15:0] == `TOK_RESTORE_HID;
    hitSaveSt = tokDone && !pendFb_r && !isLong &&
                nTok[15:0] == `TOK_SAVE_STARTUP;
    hitReboot = tokDone && !pendFb_r && !isLong &&
                nTok[15:0] == `TOK_REBOOT;
    hitRestC = tokDone && isLong && nTok == `TOK_RESTORE_COM;
    hitLoadCu = tokDone && isLong && nTok == `TOK_LOAD_CUSTOM;
    hitSaveCu = tokDone && isLong && nTok == `TOK_SAVE_CUSTOM;
    hitSetLine = tokDone && isLong && nTok == `TOK_SET_LINE;
    hitOutLine = tokDone && isLong && nTok == `TOK_OUT_LINE;
    hitFbCmd = tokDone && isLong && nTok == `TOK_FAST_BOOT;
    hitUnknown = tokDone && !pendFb_r && !(hitRestU || hitRestH ||
                 hitSaveSt || hitReboot || hitRestC || hitLoadCu ||
                 hitSaveCu || hitSetLine || hitOutLine || hitFbCmd);
    bootDone = (bootCnt_r == 32'(BOOT_CYCLES - 1));
  end

  // ---------------------------------------------------------------
  // copy requests
  // ---------------------------------------------------------------
  always_comb begin
    cpStart = 1'b1;
    cpSrcN = AREA_FACTORY;
    cpDstN = AREA_ACTIVE;
    cpIfN = IF_UART;
    if (hitReboot) begin
      if (!fbMode_r && stValid_r) begin
        cpSrcN = AREA_STARTUP;
      end
    end else if (hitRestU) begin
      cpIfN = IF_UART;
    end else if (hitRestC) begin
      cpIfN = IF_USBCOM;
    end else if (hitRestH) begin
      cpIfN = IF_USBHID;
    end else if (hitSaveSt) begin
      cpSrcN = AREA_ACTIVE;
      cpDstN = AREA_STARTUP;
    end else if (hitLoadCu && cuValid_r) begin
      cpSrcN = AREA_CUSTOM;
    end else if (hitSaveCu) begin
      cpSrcN = AREA_ACTIVE;
      cpDstN = AREA_CUSTOM;
    end else begin
      cpStart = 1'b0;
    end
    case (cpSrc_r)
      AREA_STARTUP: cpWord = stMem[cpIdx_r];
      AREA_CUSTOM: cpWord = cuMem[cpIdx_r];
      AREA_ACTIVE: cpWord = actMem[cpIdx_r];
      default: cpWord = factoryWord(cpIf_r, cpIdx_r);
    endcase
  end

  // ---------------------------------------------------------------
  // copy engine, one word per cycle
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpAct_r <= 1'b1;
      cpIdx_r <= '0;
      cpSrc_r <= AREA_FACTORY;
      cpDst_r <= AREA_ACTIVE;
      cpIf_r <= IF_UART;
      stValid_r <= 1'b0;
      cuValid_r <= 1'b0;
      deferred_r <= '0;
    end else begin
      if (cpStart) begin
        cpAct_r <= 1'b1;
        cpIdx_r <= '0;
        cpSrc_r <= cpSrcN;
        cpDst_r <= cpDstN;
        cpIf_r <= cpIfN;
      end else if (cpAct_r) begin
        if (cpIdx_r == AW'(NW - 1)) begin
          cpAct_r <= 1'b0;
          if (cpDst_r == AREA_STARTUP) begin
            stValid_r <= 1'b1;
          end
          if (cpDst_r == AREA_CUSTOM) begin
            cuValid_r <= 1'b1;
          end
        end else begin
          cpIdx_r <= AW'(cpIdx_r + 1'b1);
        end
      end
      // baud-like settings follow active only on save or boot
      if (cpAct_r && cpIdx_r == AW'(DEFER_IDX) &&
          (cpDst_r == AREA_STARTUP || state_r == ST_BOOT)) begin
        deferred_r <= cpWord;
      end
    end
  end

  // non-volatile areas modelled as plain arrays without reset
  always_ff @(posedge core_clk) begin
    if (cpAct_r) begin
      case (cpDst_r)
        AREA_ACTIVE: actMem[cpIdx_r] <= cpWord;
        AREA_STARTUP: stMem[cpIdx_r] <= cpWord;
        AREA_CUSTOM: cuMem[cpIdx_r] <= cpWord;
        default: ;
      endcase
    end else if (setWrEn) begin
      actMem[setAddr] <= setWrData;
    end
    if (state_r == ST_CLCAP && take && capOpen_r && !isTerm &&
        rxData != `CH_APOS && clCnt_r < EW'(CL_DEPTH)) begin
      clMem[clCnt_r[CW-1:0]] <= rxData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      setRdData_r <= '0;
    end else begin
      setRdData_r <= actMem[setAddr];
    end
  end

  // ---------------------------------------------------------------
  // boot timing and reboot
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bootCnt_r <= '0;
      cmdReady_r <= 1'b0;
      rebootPulse_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      rebootPulse_r <= hitReboot;
      if (hitReboot) begin
        bootCnt_r <= '0;
        cmdReady_r <= 1'b0;
        armed_r <= clValid_r;
      end else if (state_r == ST_BOOT) begin
        if (!bootDone) begin
          bootCnt_r <= bootCnt_r + 32'h1;
        end else if (!cpAct_r) begin
          cmdReady_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // custom line and fast boot mode
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clCnt_r <= '0;
      clLen_r <= '0;
      clValid_r <= 1'b0;
      capOpen_r <= 1'b0;
      fbMode_r <= 1'b0;
    end else begin
      if (hitSetLine) begin
        clCnt_r <= '0;
        capOpen_r <= 1'b0;
      end else if (state_r == ST_CLCAP && take) begin
        if (isTerm) begin
          // an interrupted write leaves no usable line
          clValid_r <= 1'b0;
          clLen_r <= '0;
        end else if (!capOpen_r) begin
          capOpen_r <= (rxData == `CH_APOS);
        end else if (rxData == `CH_APOS) begin
          clLen_r <= clCnt_r;
          clValid_r <= (clCnt_r != '0);
        end else if (clCnt_r < EW'(CL_DEPTH)) begin
          clCnt_r <= EW'(clCnt_r + 1'b1);
        end
      end
      if (hitFbSet) begin
        fbMode_r <= (nTok[7:0] == `CH_ONE);
      end
    end
  end

  // ---------------------------------------------------------------
  // emitter byte source
  // ---------------------------------------------------------------
  always_comb begin
    txFree = !txValid_r || txReady;
    fwdFree = !fwdValid_r || fwdReady;
    emLoad = (emIdx_r != emLen_r) &&
             ((state_r == ST_TX && txFree) ||
              ((state_r == ST_FWD || state_r == ST_REPLAY) && fwdFree));
    emIsLast = emLast_r && (emIdx_r == EW'(emLen_r - 1'b1));
    if (state_r == ST_FWD) begin
      emByte = fwdBuf_r[8*(emLen_r - 1 - emIdx_r) +: 8];
    end else if (state_r == ST_REPLAY || txLine_r) begin
      emByte = clMem[emIdx_r[CW-1:0]];
    end else if (fbMode_r) begin
      emByte = MSG_EN[8*(`MSG_EN_LEN - 1 - emIdx_r) +: 8];
    end else begin
      emByte = MSG_DIS[8*(`MSG_DIS_LEN - 1 - emIdx_r) +: 8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txValid_r <= 1'b0;
      txData_r <= 8'h00;
      fwdValid_r <= 1'b0;
      fwdBeat_r <= '0;
    end else begin
      if (emLoad && state_r == ST_TX) begin
        txValid_r <= 1'b1;
        txData_r <= emByte;
      end else if (txReady) begin
        txValid_r <= 1'b0;
      end
      if (emLoad && state_r != ST_TX) begin
        fwdValid_r <= 1'b1;
        fwdBeat_r <= '{last: emIsLast, data: emByte};
      end else if (fwdReady) begin
        fwdValid_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_BOOT;
      retState_r <= ST_IDLE;
      tokVal_r <= '0;
      tokCnt_r <= 3'h0;
      tokLong_r <= 1'b0;
      hdrStx_r <= 1'b0;
      pendFb_r <= 1'b0;
      replayPend_r <= 1'b0;
      txLine_r <= 1'b0;
      emIdx_r <= '0;
      emLen_r <= '0;
      emLast_r <= 1'b0;
      fwdBuf_r <= '0;
    end else begin
      case (state_r)
        ST_BOOT: begin
          if (bootDone && !cpAct_r) begin
            retState_r <= ST_IDLE;
            replayPend_r <= 1'b0;
            emIdx_r <= '0;
            emLen_r <= clLen_r;
            emLast_r <= 1'b1;
            state_r <= replayPend_r ? ST_REPLAY : ST_IDLE;
          end
        end
        ST_IDLE: begin
          tokCnt_r <= 3'h0;
          tokLong_r <= 1'b0;
          pendFb_r <= 1'b0;
          if (take && (rxData == `CH_ESC || rxData == `CH_STX)) begin
            hdrStx_r <= (rxData == `CH_STX);
            state_r <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (hitFbQuery) begin
            pendFb_r <= 1'b0;
            tokCnt_r <= 3'h0;
            tokLong_r <= 1'b0;
            txLine_r <= 1'b0;
            emIdx_r <= '0;
            emLen_r <= fbMode_r ? EW'(`MSG_EN_LEN) : EW'(`MSG_DIS_LEN);
            retState_r <= ST_BODY;
            state_r <= ST_TX;
          end else if (take && isTerm) begin
            // terminator closes the forwarded packet
            fwdBuf_r <= nTok;
            emIdx_r <= '0;
            emLen_r <= EW'(nCnt);
            emLast_r <= 1'b1;
            retState_r <= ST_IDLE;
            state_r <= ST_FWD;
          end else if (tokDone) begin
            tokCnt_r <= 3'h0;
            tokLong_r <= 1'b0;
            retState_r <= ST_BODY;
            emIdx_r <= '0;
            if (hitFbSet) begin
              pendFb_r <= 1'b0;
            end else if (hitFbCmd) begin
              pendFb_r <= 1'b1;
            end else if (hitOutLine) begin
              txLine_r <= 1'b1;
              emLen_r <= clLen_r;
              if (clValid_r) begin
                state_r <= ST_TX;
              end
            end else if (hitSetLine) begin
              state_r <= ST_CLCAP;
            end else if (hitReboot) begin
              replayPend_r <= fbMode_r && clValid_r;
              state_r <= ST_BOOT;
            end else if (cpStart) begin
              replayPend_r <= hitRestU && armed_r && clValid_r;
              state_r <= ST_COPY;
            end else if (hitUnknown) begin
              fwdBuf_r <= nTok;
              emLen_r <= isLong ? EW'(4) : EW'(2);
              emLast_r <= 1'b0;
              state_r <= ST_FWD;
            end
          end else if (take) begin
            tokVal_r <= nTok;
            tokCnt_r <= nCnt;
            tokLong_r <= isLong;
          end
        end
        ST_COPY: begin
          if (!cpAct_r) begin
            replayPend_r <= 1'b0;
            emIdx_r <= '0;
            emLen_r <= clLen_r;
            emLast_r <= 1'b1;
            state_r <= replayPend_r ? ST_REPLAY : retState_r;
          end
        end
        ST_CLCAP: begin
          if (take && isTerm) begin
            state_r <= ST_IDLE;
          end else if (take && capOpen_r && rxData == `CH_APOS) begin
            state_r <= ST_BODY;
          end
        end
        default: begin
          if (emIdx_r == emLen_r) begin
            txLine_r <= 1'b0;
            state_r <= retState_r;
          end else if (emLoad) begin
            emIdx_r <= EW'(emIdx_r + 1'b1);
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign txValid = txValid_r;
  assign txData = txData_r;
  assign fwdValid = fwdValid_r;
  assign fwdBeat = fwdBeat_r;
  assign setRdData = setRdData_r;
  assign setBusy = cpAct_r;
  assign cmdReady = cmdReady_r;
  assign engineReboot = rebootPulse_r;
  assign fastBootOn = fbMode_r;
  assign deferredCfg = deferred_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_boot_copy_done: assert property (
    $fell(state_r == ST_BOOT) |-> !$past(cpAct_r))
    else $error("boot left before area copy finished");
  a_boot_ready_time: assert property (
    $fell(state_r == ST_BOOT) |->
      cmdReady && $past(bootCnt_r) == 32'(BOOT_CYCLES - 1))
    else $error("ready not tied to boot count");
  a_load_custom_go: assert property (
    hitLoadCu && cuValid_r |=>
      cpAct_r && cpSrc_r == AREA_CUSTOM && cpDst_r == AREA_ACTIVE)
    else $error("custom load did not start");
  a_save_custom_go: assert property (
    hitSaveCu |=> cpAct_r && cpSrc_r == AREA_ACTIVE &&
      cpDst_r == AREA_CUSTOM ##1 state_r == ST_COPY && !rxReady)
    else $error("custom save did not start");
  a_restore_iface: assert property (
    hitRestH |=> cpSrc_r == AREA_FACTORY && cpIf_r == IF_USBHID)
    else $error("hid restore used wrong defaults");
  a_save_startup_go: assert property (
    hitSaveSt |=> cpDst_r == AREA_STARTUP && cpIdx_r == '0 && cpAct_r)
    else $error("startup save did not start");
  a_defer_hold: assert property (
    $changed(deferred_r) |-> $past(cpAct_r) &&
      ($past(cpDst_r) == AREA_STARTUP || $past(state_r) == ST_BOOT))
    else $error("deferred setting changed without save");
  a_replay_armed: assert property (
    hitRestU && !armed_r |=> !replayPend_r)
    else $error("redefined defaults applied before reboot");
  a_reboot_pulse: assert property (
    hitReboot |=> engineReboot && state_r == ST_BOOT ##1 !engineReboot)
    else $error("reboot not one pulse into boot");
  a_empty_line: assert property (
    hitOutLine && !clValid_r |=> state_r != ST_TX [*2])
    else $error("empty custom line produced output");
  a_fast_boot_src: assert property (
    engineReboot && fbMode_r |-> cpSrc_r == AREA_FACTORY)
    else $error("fast boot loaded startup area");
  a_query_len: assert property (
    hitFbQuery |=> state_r == ST_TX && emLen_r ==
      (fbMode_r ? EW'(`MSG_EN_LEN) : EW'(`MSG_DIS_LEN)))
    else $error("fast boot answer has wrong length");

  c_boot_done: cover property ($fell(state_r == ST_BOOT));
  c_line_commit: cover property (
    state_r == ST_CLCAP ##1 state_r == ST_BODY && clValid_r);
  c_fb_answer: cover property (
    state_r == ST_TX && !txLine_r && emIdx_r == emLen_r);
endmodule
`default_nettype wire

/* verif/host_cmd_source.sv */
`timescale 1ns/100ps
`default_nettype none
`include "settings_store_consts.svh"
module host_cmd_source (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // command bytes
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic rxReady
);
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
  end
  // valid held across bytes, so no double assignment per step
  // a stuck byte is caught by the bench cycle ceiling
  task automatic send(input logic [7:0] b);
    rxValid <= 1'b1;
    rxData <= b;
    do begin
      @(negedge core_clk);
    end while (rxReady !== 1'b1);
    @(posedge core_clk);
  endtask
  // short packets, few saves, never near a power drop
  // zero bytes in the body word are padding and not sent
  task automatic pkt(input logic [63:0] v, input logic stx = 1'b0);
    send(stx ? `CH_STX : `CH_ESC);
    for (int i = 7; i >= 0; i--) begin
      if (v[8*i +: 8] != 8'h00) send(v[8*i +: 8]);
    end
    send(stx ? `CH_ETX : `CH_CR);
    rxValid <= 1'b0;
    rxData <= 8'hf2;
  endtask
endmodule
`default_nettype wire

/* verif/settings_store_command_unit_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "settings_store_consts.svh"
module settings_store_command_unit_test;
  import settings_store_pkg::*;
  localparam logic [15:0] SEED = 16'h5a00;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxValid, rxReady, txValid, fwdValid;
  logic txReady = 1'b1;
  logic fwdReady = 1'b1;
  logic [7:0] rxData, txData;
  fwd_beat_t fwdBeat;
  logic setWrEn = 1'b0;
  logic setBusy, cmdReady, engineReboot, fastBootOn;
  logic [3:0] setAddr = 4'h0;
  logic [15:0] setWrData = 16'h0000;
  logic [15:0] setRdData, deferredCfg;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int boots = 0;
  logic [7:0] txq[$];
  logic [8:0] fq[$];
  logic [19:0] rows[3] = '{20'h1_1234, 20'h7_beef, 20'hf_0001};
  logic [31:0] toks[3] = '{{16'h0000, `TOK_RESTORE_UART},
    `TOK_RESTORE_COM, {16'h0000, `TOK_RESTORE_HID}};
  always #20 core_clk = ~core_clk;
  host_cmd_source host (.core_clk(core_clk), .rst_n(rst_n),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady));
  settings_store_command_unit #(.BOOT_CYCLES(20), .FACTORY_SEED(SEED))
    dut (
    .core_clk(core_clk), .rst_n(rst_n), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .txValid(txValid),
    .txData(txData), .txReady(txReady), .fwdValid(fwdValid),
    .fwdBeat(fwdBeat), .fwdReady(fwdReady), .setWrEn(setWrEn),
    .setAddr(setAddr), .setWrData(setWrData), .setRdData(setRdData),
    .setBusy(setBusy), .cmdReady(cmdReady), .engineReboot(engineReboot),
    .fastBootOn(fastBootOn), .deferredCfg(deferredCfg));
  // --------------------------------
  // monitors and timeout
  // --------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (txValid && txReady) txq.push_back(txData);
    if (fwdValid && fwdReady) fq.push_back(fwdBeat);
    if (engineReboot === 1'b1) boots++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // bounded wait for boot, copies and answers to finish
  task automatic cmd(input logic [63:0] v, input logic stx = 1'b0);
    int n;
    host.pkt(v, stx);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((cmdReady !== 1'b1 || setBusy !== 1'b0 || rxReady !== 1'b1)
               && n < 300);
    if (cmdReady !== 1'b1 || setBusy !== 1'b0 || rxReady !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t command did not settle", $time);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    setWrEn <= 1'b1;
    setAddr <= a;
    setWrData <= d;
    @(posedge core_clk);
    setWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    setAddr <= a;
    repeat (2) @(posedge core_clk);
    chk(setRdData, exp);
  endtask
  task automatic msg(input string s);
    chk(16'(txq.size()), 16'(s.len() + 1));
    for (int i = 0; i < s.len(); i++) chk(16'(txq[i]), 16'(s[i]));
    chk(16'(txq[s.len()]), 16'h000d);
    txq.delete();
  endtask
  task automatic complete_run();
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(16'(setBusy), 16'h0001);
    chk(16'(cmdReady), 16'h0000);
    cmd(64'h0);
    chk(16'(cmdReady), 16'h0001);
    rd(4'h5, SEED ^ 16'h0005);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:0]);
      rd(rows[i][19:16], rows[i][15:0]);
    end
    wr(4'h3, 16'h00c3);
    cmd(64'(`TOK_SAVE_CUSTOM));
    wr(4'h3, 16'h0033);
    cmd(64'(`TOK_LOAD_CUSTOM));
    rd(4'h3, 16'h00c3);
    wr(4'h0, 16'h0abc);
    chk(deferredCfg, SEED);
    cmd(64'(`TOK_SAVE_STARTUP));
    chk(deferredCfg, 16'h0abc);
    // custom load first, restore last: order decides the result
    foreach (toks[i]) begin
      wr(4'h3, 16'hffff);
      cmd({`TOK_LOAD_CUSTOM, toks[i]});
      rd(4'h3, SEED ^ {10'h000, 2'(i), 4'h3});
    end
    txq.delete();
    cmd(64'(`TOK_OUT_LINE));
    chk(16'(txq.size()), 16'h0000);
    cmd({`TOK_SET_LINE, `CH_APOS, 16'h5743, `CH_APOS});
    cmd(64'(`TOK_OUT_LINE));
    chk(16'(txq.size()), 16'h0002);
    chk({txq[0], txq[1]}, 16'h5743);
    cmd(64'(`TOK_REBOOT));
    chk(16'(boots), 16'h0001);
    fq.delete();
    cmd(64'(`TOK_RESTORE_UART));
    chk(16'(fq[0]), 16'h0057);
    chk(16'(fq[1]), 16'h0143);
    txq.delete();
    cmd(64'(`TOK_FAST_BOOT));
    msg("Disable Fast Boot Mode");
    cmd(64'({`TOK_FAST_BOOT, `TOK_FB_ON}));
    chk(16'(fastBootOn), 16'h0001);
    cmd(64'(`TOK_FAST_BOOT));
    msg("Enable Fast Boot Mode");
    wr(4'h5, 16'h1111);
    cmd(64'({`TOK_SAVE_STARTUP, `TOK_REBOOT}));
    rd(4'h5, SEED ^ 16'h0005);
    cmd(64'({`TOK_FAST_BOOT, `TOK_FB_OFF}));
    chk(16'(fastBootOn), 16'h0000);
    // stx framing: unknown token goes out, etx closes with last set
    fq.delete();
    cmd(64'h5743, 1'b1);
    chk(16'(fq.size()), 16'h0003);
    chk(16'(fq[0]), 16'h0057);
    chk(16'(fq[1]), 16'h0043);
    chk(16'(fq[2]), 16'h0103);
    complete_run();
  end
endmodule
`default_nettype wire
